// *** hw/nvmac_top.sv ***
// Byte memory access controller with unlock sequence and self-timed writes, behind APB.
// Notes on behaviour
// - A read puts the addressed byte in the byte buffer by the very next cycle.
// - The byte buffer keeps a read result until another read or a software write to it.
// - A write starts only after the keys 55h then aah are written and the write trigger is set next.
// - The write trigger cannot be set unless modify permit is already set.
// - One write cannot set both write trigger and modify permit.
// - During a write cycle the control, address and byte buffer registers ignore writes.
// - At the end of a write cycle the trigger clears and the cycle done flag sets.
// - The cycle done flag stays set until software clears it.
// - Hardware never clears modify permit.
// - The read trigger self-clears and cannot be set while either space select is 1.
// - The configuration space select routes write cycles to configuration registers when 1.
// - The row erase bit makes the next write trigger to the data memory an erase instead of a write; configuration writes ignore it.
`timescale 1ns/1ps
`default_nettype none
module nvmac_top (
  // APB slave
  input  wire logic        pclk,
  input  wire logic        presetn,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [11:0] paddr,
  input  wire logic [31:0] pwdata,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  // Status
  output logic             busy,
  output logic             mem_erase_q,
  output logic             cfg_target
);
  logic [7:0]  mem_q [256];
  logic [7:0]  cfg_q [256];
  logic [7:0]  nvm_address_q;
  logic [7:0]  nvm_byte_buffer_q;
  logic [7:0]  ctrl_q;
  logic        done_q;
  logic [15:0] timer_q;
  logic        erase_run_q;
  nvmac_pkg::nvmac_key_t key_q;
  logic [31:0] prdata_q;
  logic        busy_q;
  logic        cfg_target_q;
  logic        pslverr_q;

  // One address compare, shared by every register select below.
  function automatic logic reg_hit(input logic [11:0] a, input logic [11:0] ofs);
    return a == ofs;
  endfunction

  wire acc      = psel & penable;
  wire setup    = psel & ~penable;
  wire wr_acc   = acc & pwrite;
  wire sel_addr = reg_hit(paddr, nvmac_pkg::ADDR_OFS);
  wire sel_buf  = reg_hit(paddr, nvmac_pkg::BUF_OFS);
  wire sel_ctrl = reg_hit(paddr, nvmac_pkg::CTRL_OFS);
  wire sel_key  = reg_hit(paddr, nvmac_pkg::KEY_OFS);
  wire sel_flag = reg_hit(paddr, nvmac_pkg::FLAG_OFS);
  wire mapped   = sel_addr | sel_buf | sel_ctrl | sel_key | sel_flag;
  wire [7:0] wb = pwdata[7:0];
  wire writing  = ctrl_q[nvmac_pkg::WR_BIT];
  wire w_ctrl   = wr_acc & sel_ctrl & ~writing;
  wire w_key    = wr_acc & sel_key;
  wire spaces_clear = ~ctrl_q[nvmac_pkg::PGM_BIT] & ~ctrl_q[nvmac_pkg::CFG_BIT];
  wire rd_go    = w_ctrl & wb[nvmac_pkg::RD_BIT] & spaces_clear;
  // Permit must already be set before this write; setting both at once fails.
  wire wr_go    = w_ctrl & wb[nvmac_pkg::WR_BIT] & ctrl_q[nvmac_pkg::PERM_BIT]
                  & (key_q == nvmac_pkg::KEY_OPEN);
  wire wr_bad   = w_ctrl & wb[nvmac_pkg::WR_BIT] & ~wr_go;
  wire finish   = writing & (timer_q == 16'h0001);
  wire to_cfg   = ctrl_q[nvmac_pkg::CFG_BIT];

  // Key sequence: any other write to the controller breaks it.
  nvmac_pkg::nvmac_key_t key_d;
  always_comb begin
    key_d = key_q;
    if (w_key && wb == nvmac_pkg::KEY_FIRST) begin
      key_d = nvmac_pkg::KEY_GOT1;
    end else if (w_key && wb == nvmac_pkg::KEY_SECOND && key_q == nvmac_pkg::KEY_GOT1) begin
      key_d = nvmac_pkg::KEY_OPEN;
    end else if (wr_acc) begin
      key_d = nvmac_pkg::KEY_IDLE;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      key_q <= nvmac_pkg::KEY_IDLE;
    end else begin
      key_q <= key_d;
    end
  end

  // Control register: write trigger is set-only, read trigger self-clears.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ctrl_q <= nvmac_pkg::CTRL_RST;
    end else begin
      ctrl_q[nvmac_pkg::RD_BIT] <= 1'b0;
      if (w_ctrl) begin
        // A refused trigger keeps the space selects so the failed target can still be read back.
        if (!wr_bad) begin
          ctrl_q[nvmac_pkg::PGM_BIT] <= wb[nvmac_pkg::PGM_BIT];
          ctrl_q[nvmac_pkg::CFG_BIT] <= wb[nvmac_pkg::CFG_BIT];
        end
        ctrl_q[nvmac_pkg::FREE_BIT] <= wb[nvmac_pkg::FREE_BIT];
        ctrl_q[nvmac_pkg::PERM_BIT] <= wb[nvmac_pkg::PERM_BIT];
        ctrl_q[nvmac_pkg::ERR_BIT]  <= wb[nvmac_pkg::ERR_BIT] | wr_bad;
      end
      if (wr_go) begin
        ctrl_q[nvmac_pkg::WR_BIT] <= 1'b1;
      end else if (finish) begin
        ctrl_q[nvmac_pkg::WR_BIT] <= 1'b0;
      end
    end
  end

  // Cycle done flag: set wins over a software clear in the same cycle.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      done_q <= 1'b0;
    end else if (finish) begin
      done_q <= 1'b1;
    end else if (wr_acc && sel_flag && wb[0]) begin
      done_q <= 1'b0;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      timer_q     <= 16'h0000;
      erase_run_q <= 1'b0;
    end else if (wr_go) begin
      timer_q     <= nvmac_pkg::WRITE_CYCLES;
      erase_run_q <= ctrl_q[nvmac_pkg::FREE_BIT];
    end else if (writing) begin
      timer_q <= timer_q - 16'h0001;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      nvm_address_q <= 8'h00;
    end else if (wr_acc && sel_addr && !writing) begin
      nvm_address_q <= wb;
    end
  end

  // Byte buffer: loaded by a read or by software, frozen during a write.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      nvm_byte_buffer_q <= 8'h00;
    end else if (rd_go) begin
      nvm_byte_buffer_q <= mem_q[nvm_address_q];
    end else if (wr_acc && sel_buf && !writing) begin
      nvm_byte_buffer_q <= wb;
    end
  end

  // Store at the end of the cycle; erase leaves a data cell blank, while a configuration cell takes the byte buffer.
  always_ff @(posedge pclk) begin
    if (finish && !to_cfg) begin
      mem_q[nvm_address_q] <= erase_run_q ? 8'hff : nvm_byte_buffer_q;
    end
    if (finish && to_cfg) begin
      cfg_q[nvm_address_q] <= nvm_byte_buffer_q;
    end
  end

  wire [7:0] rd_byte = sel_addr ? nvm_address_q :
                       sel_buf  ? nvm_byte_buffer_q :
                       sel_ctrl ? {ctrl_q[7:6], 1'b0, ctrl_q[4:0]} :
                       sel_flag ? {7'h00, done_q} : 8'h00;

  // Zero-wait APB: pready answers in the access phase itself.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata_q  <= 32'h0000_0000;
      busy_q    <= 1'b0;
      cfg_target_q <= 1'b0;
      pslverr_q    <= 1'b0;
    end else begin
      prdata_q     <= {24'h000000, rd_byte};
      busy_q       <= writing;
      cfg_target_q <= to_cfg;
      // Decided in the setup cycle, so the error stands from a flop at the access edge.
      pslverr_q    <= setup & ~mapped;
    end
  end

  assign prdata      = prdata_q;
  assign pready      = 1'b1;
  assign pslverr     = pslverr_q;
  assign busy        = busy_q;
  assign mem_erase_q = erase_run_q;
  assign cfg_target  = cfg_target_q;

  // Length of the running write, counted here so the check needs no long repetition.
  logic [15:0] run_len_q;
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      run_len_q <= 16'h0000;
    end else if (writing) begin
      run_len_q <= run_len_q + 16'h0001;
    end else begin
      run_len_q <= 16'h0000;
    end
  end

  // Bus inputs appear as triggers and in the $past checks of done_sticky_a and permit_kept_a; other consequents watch state this block drives.
  trig_perm_a: assert property (@(posedge pclk) disable iff (!presetn)
    $rose(ctrl_q[nvmac_pkg::WR_BIT]) |-> $past(ctrl_q[nvmac_pkg::PERM_BIT]))
    else $error("trigger set without permit");

  trig_keys_a: assert property (@(posedge pclk) disable iff (!presetn)
    $rose(ctrl_q[nvmac_pkg::WR_BIT]) |-> $past(key_q) == nvmac_pkg::KEY_OPEN)
    else $error("trigger set without keys");

  both_bits_a: assert property (@(posedge pclk) disable iff (!presetn)
    w_ctrl && wb[nvmac_pkg::WR_BIT] && wb[nvmac_pkg::PERM_BIT] && !ctrl_q[nvmac_pkg::PERM_BIT]
      |=> !ctrl_q[nvmac_pkg::WR_BIT])
    else $error("trigger and permit set by one write");

  key_reset_a: assert property (@(posedge pclk) disable iff (!presetn)
    wr_acc && !w_key |=> key_q == nvmac_pkg::KEY_IDLE)
    else $error("key sequence survived another write");

  done_sets_a: assert property (@(posedge pclk) disable iff (!presetn)
    $fell(ctrl_q[nvmac_pkg::WR_BIT]) |-> done_q)
    else $error("done flag not set at cycle end");

  write_time_a: assert property (@(posedge pclk) disable iff (!presetn)
    $fell(writing) |-> run_len_q == nvmac_pkg::WRITE_CYCLES)
    else $error("write cycle length wrong");

  done_sticky_a: assert property (@(posedge pclk) disable iff (!presetn)
    $fell(done_q) |-> $past(wr_acc && sel_flag))
    else $error("done flag cleared by hardware");

  done_clear_a: assert property (@(posedge pclk) disable iff (!presetn)
    wr_acc && sel_flag && wb[0] && !finish |=> !done_q)
    else $error("done flag not cleared by software");

  permit_kept_a: assert property (@(posedge pclk) disable iff (!presetn)
    $fell(ctrl_q[nvmac_pkg::PERM_BIT]) |-> $past(w_ctrl))
    else $error("permit cleared by hardware");

  addr_frozen_a: assert property (@(posedge pclk) disable iff (!presetn)
    writing && $past(writing) |-> $stable(nvm_address_q))
    else $error("address changed during write");

  buf_frozen_a: assert property (@(posedge pclk) disable iff (!presetn)
    writing && $past(writing) |-> $stable(nvm_byte_buffer_q))
    else $error("byte buffer changed during write");

  ctrl_frozen_a: assert property (@(posedge pclk) disable iff (!presetn)
    writing && $past(writing) |-> $stable(ctrl_q))
    else $error("control changed during write");

  read_block_a: assert property (@(posedge pclk) disable iff (!presetn)
    w_ctrl && wb[nvmac_pkg::RD_BIT] && !spaces_clear |=> $stable(nvm_byte_buffer_q))
    else $error("read ran with a space select set");

  write_len_a: assert property (@(posedge pclk) disable iff (!presetn)
    $rose(writing) |-> writing [*8])
    else $error("write cycle ended early");

  read_data_a: assert property (@(posedge pclk) disable iff (!presetn)
    rd_go |=> nvm_byte_buffer_q == mem_q[$past(nvm_address_q)])
    else $error("read data not ready next cycle");

  rd_keep_a: assert property (@(posedge pclk) disable iff (!presetn)
    !rd_go && !(wr_acc && sel_buf && !writing) |=> $stable(nvm_byte_buffer_q))
    else $error("byte buffer lost its value");

  erase_latch_a: assert property (@(posedge pclk) disable iff (!presetn)
    wr_go |=> mem_erase_q == $past(ctrl_q[nvmac_pkg::FREE_BIT]))
    else $error("erase choice not latched at trigger");

  mem_store_a: assert property (@(posedge pclk) disable iff (!presetn)
    finish && !to_cfg |=> mem_q[$past(nvm_address_q)] ==
      ($past(erase_run_q) ? 8'hff : $past(nvm_byte_buffer_q)))
    else $error("data cell not stored at cycle end");

  cfg_route_a: assert property (@(posedge pclk) disable iff (!presetn)
    finish && to_cfg |=> cfg_q[$past(nvm_address_q)] == $past(nvm_byte_buffer_q))
    else $error("configuration cell not stored at cycle end");

  trace_keep_a: assert property (@(posedge pclk) disable iff (!presetn)
    wr_bad |=> ctrl_q[nvmac_pkg::ERR_BIT] && $stable(ctrl_q[nvmac_pkg::PGM_BIT])
      && $stable(ctrl_q[nvmac_pkg::CFG_BIT]))
    else $error("refused trigger lost its trace");

  err_resp_a: assert property (@(posedge pclk) disable iff (!presetn)
    setup && !mapped |=> pslverr)
    else $error("no error answer on unmapped address");

  c_write: cover property (@(posedge pclk) disable iff (!presetn) finish);
  c_read: cover property (@(posedge pclk) disable iff (!presetn) rd_go);
  c_bad: cover property (@(posedge pclk) disable iff (!presetn) wr_bad);
  c_erase: cover property (@(posedge pclk) disable iff (!presetn) finish && erase_run_q);
  c_unmapped: cover property (@(posedge pclk) disable iff (!presetn) pslverr);
endmodule // nvmac_top
`default_nettype wire

// *** shared/nvmac_pkg.sv ***
// Package with register map, field positions and timing for the byte memory access controller.
`default_nettype none
package nvmac_pkg;
  // Register byte addresses on the APB slave.
  localparam logic [11:0] ADDR_OFS    = 12'h000;
  localparam logic [11:0] BUF_OFS     = 12'h004;
  localparam logic [11:0] CTRL_OFS    = 12'h008;
  localparam logic [11:0] KEY_OFS     = 12'h00c;
  localparam logic [11:0] FLAG_OFS    = 12'h010;
  // Control register field positions.
  localparam int RD_BIT   = 0;
  localparam int WR_BIT   = 1;
  localparam int PERM_BIT = 2;
  localparam int ERR_BIT  = 3;
  localparam int FREE_BIT = 4;
  localparam int CFG_BIT  = 6;
  localparam int PGM_BIT  = 7;
  localparam logic [7:0] CTRL_RST = 8'h00;
  localparam logic [7:0] KEY_FIRST  = 8'h55;
  localparam logic [7:0] KEY_SECOND = 8'haa;
  // Self-timed write cycle length.
  localparam int  CLK_MHZ     = 50;
  localparam int  WRITE_US    = 4;
  localparam logic [15:0] WRITE_CYCLES = 16'(WRITE_US * CLK_MHZ);
  typedef enum logic [1:0] {
    KEY_IDLE = 2'b00,
    KEY_GOT1 = 2'b01,
    KEY_OPEN = 2'b10
  } nvmac_key_t;
endpackage
`default_nettype wire

// *** verification/data_eeprom_access_control_test.sv ***
// Self-checking APB testbench for the byte memory access controller.
`timescale 1ns/1ps
`default_nettype none
module data_eeprom_access_control_test;
  localparam logic [11:0] A = nvmac_pkg::ADDR_OFS;
  localparam logic [11:0] B = nvmac_pkg::BUF_OFS;
  localparam logic [11:0] C = nvmac_pkg::CTRL_OFS;
  localparam logic [11:0] K = nvmac_pkg::KEY_OFS;
  localparam logic [11:0] F = nvmac_pkg::FLAG_OFS;
  logic        pclk, presetn, psel, penable, pwrite, pready, pslverr, busy, mem_erase_q, cfg_target, err;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, rd;
  logic [7:0]  sel;
  int          bad_count, n_tests;

  nvmac_top i_dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .busy(busy), .mem_erase_q(mem_erase_q), .cfg_target(cfg_target));

  initial begin
    pclk = 1'b0;
    forever #10 pclk = ~pclk;
  end

  task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    n_tests++;
    if (seen !== exp) begin
      bad_count++;
      $display("MISMATCH %s expected %h seen %h", nm, exp, seen);
    end
  endtask

  // One idle cycle follows each transfer, so no strobe is assigned twice in a time step.
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do @(posedge pclk); while (pready !== 1'b1);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
  endtask

  task automatic wr(input logic [11:0] a, input logic [7:0] d);
    apb(1'b1, a, {24'h0, d});
  endtask

  task automatic rchk(input string nm, input logic [11:0] a, input logic [31:0] exp);
    apb(1'b0, a, 32'h0);
    chk(nm, rd, exp);
  endtask

  task automatic unlock(input logic [7:0] c);
    wr(K, nvmac_pkg::KEY_FIRST);
    wr(K, nvmac_pkg::KEY_SECOND);
    wr(C, c);
    @(posedge pclk);
  endtask

  task automatic wait_done;
    int n = 0;
    while (busy !== 1'b0 && n < 1000) begin
      @(posedge pclk);
      n++;
    end
    if (busy !== 1'b0) bad_count++;
  endtask

  task automatic finish_test;
    $display("checks %0d mismatches %0d", n_tests, bad_count);
    if (bad_count == 0 && n_tests > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask

  initial begin
    #(20 * 20000);
    bad_count++;
    finish_test;
  end

  initial begin
    presetn = 1'b0;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 12'h000;
    pwdata = 32'h0;
    bad_count = 0;
    n_tests = 0;
    repeat (5) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    rchk("ctrl_reset", C, 32'h0);
    wr(A, 8'h12);
    wr(B, 8'ha5);
    wr(C, 8'h04);
    unlock(8'h06);
    chk("busy_run", busy, 32'h1);
    wr(A, 8'h34);
    wr(B, 8'h00);
    wr(C, 8'h00);
    rchk("addr_hold", A, 32'h12);
    rchk("ctrl_hold", C, 32'h06);
    wait_done;
    rchk("ctrl_done", C, 32'h04);
    rchk("flag_set", F, 32'h1);
    repeat (50) @(posedge pclk);
    rchk("flag_hold", F, 32'h1);
    wr(F, 8'h01);
    rchk("flag_clr", F, 32'h0);
    wr(B, 8'h00);
    wr(C, 8'h05);
    rchk("rd_data", B, 32'ha5);
    rchk("rd_self_clr", C, 32'h04);
    rchk("rd_keep", B, 32'ha5);
    wr(C, 8'hc4);
    wr(K, 8'haa);
    wr(K, 8'h55);
    wr(C, 8'hc6);
    rchk("bad_keys", C, 32'hcc);
    wr(C, 8'h06);
    rchk("err_trace", C, 32'hcc);
    wr(C, 8'h04);
    wr(K, 8'h55);
    wr(A, 8'h12);
    wr(K, 8'haa);
    wr(C, 8'h06);
    rchk("key_break", C, 32'h0c);
    wr(C, 8'h00);
    unlock(8'h02);
    rchk("no_permit", C, 32'h08);
    wr(C, 8'h00);
    unlock(8'h06);
    apb(1'b0, C, 32'h0);
    chk("same_write", rd[1], 32'h0);
    foreach (sel[i]) if (i >= 6) begin
      wr(C, 8'h00);
      wr(B, 8'h3c);
      wr(C, 8'h01 << i);
      wr(C, 8'h01 | (8'h01 << i));
      rchk("sel_rd", B, 32'h3c);
      chk("cfg_target", cfg_target, (i == 6) ? 32'h1 : 32'h0);
    end
    wr(C, 8'h00);
    wr(C, 8'h14);
    unlock(8'h16);
    chk("erase_run", mem_erase_q, 32'h1);
    wait_done;
    wr(C, 8'h05);
    rchk("erased", B, 32'hff);
    apb(1'b0, 12'h020, 32'h0);
    chk("unmapped", err, 32'h1);
    finish_test;
  end
endmodule // data_eeprom_access_control_test
`default_nettype wire
